// ---- shared/lsi_pkg.sv ----
// constants and types for the light sensor interrupt control block
package lsi_pkg;
    localparam logic [7:0] LSI_INT_CTRL_ADDR = 8'h02;
    localparam logic [7:0] LSI_INT_CTRL_RESET = 8'h00;
    localparam logic [7:0] LSI_INT_CTRL_WMASK = 8'h77;
    localparam int LSI_HALT_BIT = 6;
    localparam int LSI_MODE_LSB = 4;
    localparam int LSI_PERSIST_LSB = 0;
    localparam logic [1:0] LSI_MODE_OFF = 2'h0;
    localparam logic [1:0] LSI_MODE_LEVEL = 2'h1;
    localparam logic [1:0] LSI_MODE_ALERT = 2'h2;
    localparam logic [1:0] LSI_MODE_FORCE = 2'h3;
    localparam logic [2:0] LSI_PERSIST_EVERY = 3'h0;
    localparam logic [2:0] LSI_PERSIST_SINGLE = 3'h1;
    localparam logic [2:0] LSI_PERSIST_SHORT = 3'h2;
    localparam logic [2:0] LSI_PERSIST_LONG = 3'h3;
    localparam int LSI_CLK_MHZ = 125;
    localparam int LSI_PERSIST_SHORT_MS = 100;
    localparam int LSI_PERSIST_LONG_MS = 1000;
    localparam int LSI_SHORT_CYC = LSI_PERSIST_SHORT_MS * 1000 * LSI_CLK_MHZ;
    localparam int LSI_LONG_CYC = LSI_PERSIST_LONG_MS * 1000 * LSI_CLK_MHZ;
    localparam int LSI_CNT_W = 27;
    localparam logic [6:0] LSI_DEV_ADDR_DEFAULT = 7'h2a;
    localparam logic [7:0] LSI_RDATA_IDLE = 8'h00;

    typedef struct packed {
        logic halt;
        logic [1:0] mode;
        logic [2:0] persist;
    } lsi_ctrl_type;
endpackage

// ---- shared/lsi_persist_if.sv ----
// carrier between control core and persistence filter
`timescale 1ns/1ps
`default_nettype none
interface lsi_persist_if;
    logic conv_done;
    logic out_of_range;
    logic [2:0] persist_sel;
    logic irq_event;
    modport filt (input conv_done, input out_of_range, input persist_sel, output irq_event);
    modport ctrl (output conv_done, output out_of_range, output persist_sel, input irq_event);
endinterface
`default_nettype wire

// ---- design/lsi_persist_filter.sv ----
// persistence filter: turns conversion results into interrupt events
`timescale 1ns/1ps
`default_nettype none
module lsi_persist_filter
    import lsi_pkg::*;
#(
    parameter int SHORT_CYC = LSI_SHORT_CYC,
    parameter int LONG_CYC = LSI_LONG_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    lsi_persist_if.filt pif
);
    typedef struct packed {
        logic oor;
        logic fired;
        logic [LSI_CNT_W-1:0] cnt;
        logic event_p;
    } lsi_filt_state_type;

    lsi_filt_state_type q, d;
    logic [LSI_CNT_W-1:0] target;

    always_comb begin
        target = (pif.persist_sel == LSI_PERSIST_LONG) ? LSI_CNT_W'(LONG_CYC - 1)
                                                       : LSI_CNT_W'(SHORT_CYC - 1);
    end

    always_comb begin
        d = q;
        d.event_p = 1'b0;
        if (pif.conv_done) begin
            d.oor = pif.out_of_range;
            if (!pif.out_of_range) begin
                d.cnt = '0;
                d.fired = 1'b0;
            end
        end else if (q.oor && q.cnt != target) begin
            d.cnt = q.cnt + 1'b1;
        end
        case (pif.persist_sel)
            LSI_PERSIST_EVERY: d.event_p = pif.conv_done;
            LSI_PERSIST_SHORT, LSI_PERSIST_LONG: begin
                // time counts only while the latest result stays out of range
                if (q.oor && q.cnt == target && !q.fired && !(pif.conv_done && !pif.out_of_range)) begin
                    d.event_p = 1'b1;
                    d.fired = 1'b1;
                end
            end
            // reserved codes act as single-out-of-range
            default: d.event_p = pif.conv_done && pif.out_of_range;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign pif.irq_event = q.event_p;

    AST_PERSIST_SINGLE: assert property (@(posedge clk) disable iff (reset)
        clk_en && pif.persist_sel == LSI_PERSIST_SINGLE && pif.conv_done && pif.out_of_range
        |=> pif.irq_event)
        else $error("single persistence missed an out of range result");
endmodule // lsi_persist_filter
`default_nettype wire

// ---- design/lsi_irq_control.sv ----
// interrupt control core: control register, pending flag, pin and halt
`timescale 1ns/1ps
`default_nettype none
module lsi_irq_control
    import lsi_pkg::*;
#(
    parameter int SHORT_CYC = LSI_SHORT_CYC,
    parameter int LONG_CYC = LSI_LONG_CYC,
    parameter logic [6:0] DEV_ADDR = LSI_DEV_ADDR_DEFAULT // value arbitrary
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic cmd_irq_clear,
    input wire logic ara_read,
    input wire logic ara_arb_lost,
    output logic ara_ack,
    output logic [7:0] ara_data,
    input wire logic conv_done,
    input wire logic conv_out_of_range,
    output logic integration_halt,
    output logic irq_pin_o,
    output logic irq_pin_oe_n
);
    typedef struct packed {
        lsi_ctrl_type ctrl;
        logic pending;
        logic irq_on;
        logic halt_on;
        logic [7:0] rdata;
        logic [7:0] alert_response_addr;
    } lsi_core_state_type;

    lsi_core_state_type q, d;
    lsi_persist_if pif ();

    logic ctrl_wr;
    logic force_wr;
    logic alert_mode;
    logic clr_level;
    logic clr_alert;

    function automatic logic is_alert(input logic [1:0] mode);
        return mode == LSI_MODE_ALERT || mode == LSI_MODE_FORCE;
    endfunction

    function automatic logic [7:0] ctrl_word(input lsi_ctrl_type c);
        return {1'b0, c.halt, c.mode, 1'b0, c.persist};
    endfunction

    assign pif.conv_done = conv_done;
    assign pif.out_of_range = conv_out_of_range;
    assign pif.persist_sel = q.ctrl.persist;

    lsi_persist_filter #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) u_filter (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .pif(pif.filt)
    );

    always_comb begin
        ctrl_wr = reg_wr && reg_addr == LSI_INT_CTRL_ADDR;
        force_wr = ctrl_wr && reg_wdata[LSI_MODE_LSB +: 2] == LSI_MODE_FORCE;
        alert_mode = is_alert(q.ctrl.mode);
        clr_level = cmd_irq_clear;
        // an alert read only clears when this device won the address phase
        clr_alert = ara_read && alert_mode && q.pending && !ara_arb_lost;
    end

    always_comb begin
        d = q;
        if (ctrl_wr) begin
            // reserved bits are dropped so they always read back zero
            d.ctrl.halt = reg_wdata[LSI_HALT_BIT];
            d.ctrl.mode = reg_wdata[LSI_MODE_LSB +: 2];
            d.ctrl.persist = reg_wdata[LSI_PERSIST_LSB +: 3];
        end
        if (clr_level || clr_alert) begin
            d.pending = 1'b0;
        end
        // a new event beats a clear in the same cycle
        if (pif.irq_event && q.ctrl.mode != LSI_MODE_OFF) begin
            d.pending = 1'b1;
        end
        if (force_wr) begin
            d.pending = 1'b1;
        end
        d.irq_on = d.pending && d.ctrl.mode != LSI_MODE_OFF;
        d.halt_on = d.ctrl.halt && d.irq_on;
        if (reg_rd) begin
            d.rdata = (reg_addr == LSI_INT_CTRL_ADDR) ? ctrl_word(q.ctrl) : LSI_RDATA_IDLE;
        end
        // a lost arbitration leaves the answer register untouched
        if (clr_alert) begin
            d.alert_response_addr = {DEV_ADDR, 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign ara_data = q.alert_response_addr;
    // answer only while this device holds an alert
    assign ara_ack = alert_mode && q.pending;
    assign integration_halt = q.halt_on;
    assign irq_pin_o = 1'b0;
    assign irq_pin_oe_n = !q.irq_on;

    AST_RESET_ZERO: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> ctrl_word(q.ctrl) == LSI_INT_CTRL_RESET && irq_pin_oe_n && !integration_halt)
        else $error("control state not zero after reset");

    AST_HALT_TIES: assert property (@(posedge clk) disable iff (reset)
        integration_halt == (q.ctrl.halt && !irq_pin_oe_n))
        else $error("integration halt does not follow interrupt and halt bit");

    AST_MODE_OFF: assert property (@(posedge clk) disable iff (reset)
        q.ctrl.mode == LSI_MODE_OFF |-> irq_pin_oe_n)
        else $error("interrupt pin driven while disabled");

    AST_FORCE_SET: assert property (@(posedge clk) disable iff (reset)
        clk_en && force_wr |=> !irq_pin_oe_n && q.pending && q.ctrl.mode == LSI_MODE_FORCE)
        else $error("forced mode did not raise interrupt");

    AST_LEVEL_SET: assert property (@(posedge clk) disable iff (reset)
        clk_en && !reg_wr && q.ctrl.mode == LSI_MODE_LEVEL && pif.irq_event |=> !irq_pin_oe_n)
        else $error("level event did not assert the pin");

    AST_HOLD: assert property (@(posedge clk) disable iff (reset)
        q.pending && !(clk_en && (clr_level || clr_alert)) |=> q.pending)
        else $error("pending interrupt dropped without a clear");

    AST_LEVEL_CLEAR: assert property (@(posedge clk) disable iff (reset)
        clk_en && cmd_irq_clear && !pif.irq_event && !force_wr |=> !q.pending)
        else $error("command clear did not drop the interrupt");

    AST_ARB_LOST: assert property (@(posedge clk) disable iff (reset)
        clk_en && ara_read && ara_arb_lost && !cmd_irq_clear && q.pending
        |=> q.pending && $stable(ara_data))
        else $error("interrupt cleared after lost arbitration");

    AST_ARA_ANSWER: assert property (@(posedge clk) disable iff (reset)
        clk_en && ara_read && !ara_arb_lost && ara_ack && !pif.irq_event && !force_wr
        |=> ara_data == {DEV_ADDR, 1'b0} && !q.pending)
        else $error("alert response did not answer and clear");

    // halt must come with the pin, never a cycle behind it
    AST_HALT_SET: assert property (@(posedge clk) disable iff (reset)
        clk_en && !ctrl_wr && q.ctrl.halt && q.ctrl.mode != LSI_MODE_OFF && pif.irq_event
        |=> integration_halt && !irq_pin_oe_n)
        else $error("integration kept running after an interrupt");

    AST_HALT_RELEASE: assert property (@(posedge clk) disable iff (reset)
        clk_en && !ctrl_wr && cmd_irq_clear && !pif.irq_event |=> !integration_halt)
        else $error("integration still halted after a clear");

    AST_HALT_NEEDS_BIT: assert property (@(posedge clk) disable iff (reset)
        clk_en && !ctrl_wr && !q.ctrl.halt |=> !integration_halt)
        else $error("integration halted with the halt bit clear");

    AST_ALERT_SET: assert property (@(posedge clk) disable iff (reset)
        clk_en && !reg_wr && q.ctrl.mode == LSI_MODE_ALERT && pif.irq_event
        |=> !irq_pin_oe_n && ara_ack)
        else $error("alert event did not assert the pin");

    // disabled output must not remember events for later
    AST_OFF_DROP: assert property (@(posedge clk) disable iff (reset)
        clk_en && !reg_wr && q.ctrl.mode == LSI_MODE_OFF && !q.pending |=> !q.pending)
        else $error("event recorded while the output is disabled");

    AST_LEVEL_ARA: assert property (@(posedge clk) disable iff (reset)
        clk_en && q.ctrl.mode == LSI_MODE_LEVEL && ara_read && !cmd_irq_clear && q.pending
        |=> q.pending)
        else $error("alert read cleared a level interrupt");

    AST_ARA_QUIET: assert property (@(posedge clk) disable iff (reset)
        clk_en && ara_read && !ara_ack |=> $stable(ara_data))
        else $error("alert answer changed without a pending alert");

    AST_FORCE_ACK: assert property (@(posedge clk) disable iff (reset)
        clk_en && force_wr |=> ara_ack)
        else $error("forced interrupt not answerable as an alert");

    AST_RESV_ZERO: assert property (@(posedge clk) disable iff (reset)
        clk_en && reg_rd |=> !reg_rdata[7] && !reg_rdata[3])
        else $error("reserved bit read back as one");

    AST_RDATA_UNMAPPED: assert property (@(posedge clk) disable iff (reset)
        clk_en && reg_rd && reg_addr != LSI_INT_CTRL_ADDR |=> reg_rdata == LSI_RDATA_IDLE)
        else $error("unmapped read returned data");

    AST_UNMAPPED_WR: assert property (@(posedge clk) disable iff (reset)
        clk_en && reg_wr && reg_addr != LSI_INT_CTRL_ADDR |=> $stable(q.ctrl))
        else $error("unmapped write changed the control register");

    AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (reset)
        !(clk_en && reg_rd) |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // a low enable freezes everything the host can see
    AST_FREEZE: assert property (@(posedge clk) disable iff (reset)
        !clk_en |=> $stable(irq_pin_oe_n) && $stable(reg_rdata) && $stable(ara_data)
        && $stable(integration_halt))
        else $error("state moved while the clock enable was low");
endmodule // lsi_irq_control
`default_nettype wire

// ---- verif/lsi_host_model.sv ----
// host side model: serial slave strobes and converter results
`timescale 1ns/1ps
`default_nettype none
module lsi_host_model (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    output logic cmd_irq_clear,
    output logic ara_read,
    output logic ara_arb_lost,
    output logic conv_done,
    output logic conv_out_of_range
);
    initial begin
        {reg_wr, reg_rd, cmd_irq_clear, ara_read, ara_arb_lost, conv_done} = 6'h00;
        {reg_addr, reg_wdata, conv_out_of_range} = 17'h00;
    end
    // released lines show the inverse, so a stale value is never mistaken for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'h0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'h1, a};
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'h0, ~a};
        @(posedge clk);
        #1 d = reg_rdata;
    endtask
    task automatic clr;
        @(posedge clk);
        cmd_irq_clear <= 1'h1;
        @(posedge clk);
        cmd_irq_clear <= 1'h0;
    endtask
    task automatic alert_response_addr(input logic lost);
        @(posedge clk);
        {ara_read, ara_arb_lost} <= {1'h1, lost};
        @(posedge clk);
        {ara_read, ara_arb_lost} <= {1'h0, ~lost};
    endtask
    task automatic conv(input logic oor);
        @(posedge clk);
        {conv_done, conv_out_of_range} <= {1'h1, oor};
        @(posedge clk);
        {conv_done, conv_out_of_range} <= {1'h0, ~oor};
    endtask
endmodule // lsi_host_model
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the interrupt control core
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lsi_pkg::*;
    localparam int SHORT = 20;
    localparam int LONG = 50;
    localparam logic [6:0] DEV = 7'h2a; // value arbitrary
    localparam logic [7:0] A = LSI_INT_CTRL_ADDR;
    localparam logic [7:0] ARA_ID = {DEV, 1'h0};
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic clk_en = 1'h1;
    logic reg_wr, reg_rd, cmd_irq_clear, ara_read, ara_arb_lost, conv_done, conv_out_of_range;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ara_data, rd;
    logic ara_ack, integration_halt, irq_pin_o, irq_pin_oe_n;
    int error_cnt = 0;
    int total_checks = 0;
    always #4 clk = ~clk;
    lsi_irq_control #(.SHORT_CYC(SHORT), .LONG_CYC(LONG), .DEV_ADDR(DEV)) dut (.clk(clk),
        .reset(reset), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmd_irq_clear(cmd_irq_clear),
        .ara_read(ara_read), .ara_arb_lost(ara_arb_lost), .ara_ack(ara_ack), .ara_data(ara_data),
        .conv_done(conv_done), .conv_out_of_range(conv_out_of_range),
        .integration_halt(integration_halt), .irq_pin_o(irq_pin_o), .irq_pin_oe_n(irq_pin_oe_n));
    lsi_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmd_irq_clear(cmd_irq_clear),
        .ara_read(ara_read), .ara_arb_lost(ara_arb_lost), .conv_done(conv_done),
        .conv_out_of_range(conv_out_of_range));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // bounded wait for the pin level, then judge it
    task automatic pin(input logic e, input int n);
        #1;
        repeat (n) begin
            if (irq_pin_oe_n === e) break;
            @(posedge clk);
            #1;
        end
        check({7'h0, irq_pin_oe_n}, {7'h0, e});
    endtask
    task automatic quiet(input logic e);
        repeat (4) @(posedge clk);
        #1 check({7'h0, irq_pin_oe_n}, {7'h0, e});
    endtask
    task automatic t_reset;
        host.rd(A, rd);
        check(rd, LSI_INT_CTRL_RESET);
        check({6'h0, integration_halt, irq_pin_oe_n}, 8'h01);
        check({7'h0, irq_pin_o}, 8'h00);
    endtask
    task automatic t_force;
        host.wr(8'h05, 8'h30);
        host.rd(8'h05, rd);
        check(rd, 8'h00);
        pin(1'h1, 1);
        host.wr(A, 8'h77);
        pin(1'h0, 2);
        host.rd(A, rd);
        check(rd, LSI_INT_CTRL_WMASK);
        check({6'h0, integration_halt, ara_ack}, 8'h03);
        host.alert_response_addr(1'h0);
        pin(1'h1, 2);
        check(ara_data, ARA_ID);
        check({7'h0, integration_halt}, 8'h00);
    endtask
    task automatic t_modes;
        host.wr(A, 8'h01);
        host.conv(1'h1);
        quiet(1'h1);
        host.wr(A, 8'h11);
        quiet(1'h1);
        host.conv(1'h0);
        quiet(1'h1);
        host.conv(1'h1);
        pin(1'h0, 3);
        host.alert_response_addr(1'h0);
        quiet(1'h0);
        host.clr;
        pin(1'h1, 2);
        host.wr(A, 8'h21);
        host.conv(1'h1);
        pin(1'h0, 3);
        host.alert_response_addr(1'h1);
        quiet(1'h0);
        host.alert_response_addr(1'h0);
        pin(1'h1, 2);
    endtask
    task automatic t_persist;
        host.wr(A, 8'h10);
        host.conv(1'h0);
        pin(1'h0, 3);
        host.clr;
        host.wr(A, 8'h12);
        host.conv(1'h1);
        quiet(1'h1);
        pin(1'h0, SHORT + 5);
        host.clr;
        pin(1'h1, 2);
    endtask
    task automatic t_halt;
        host.conv(1'h0);
        host.wr(A, 8'h51);
        host.conv(1'h1);
        pin(1'h0, 3);
        quiet(1'h0);
        check({7'h0, integration_halt}, 8'h01);
        host.clr;
        quiet(1'h1);
        check({7'h0, integration_halt}, 8'h00);
    endtask
    // long persistence, a frozen stretch, reserved persist code, mid-run reset
    task automatic t_long;
        host.conv(1'h0);
        host.wr(A, 8'h13);
        host.conv(1'h1);
        repeat (LONG - 6) @(posedge clk);
        #1 check({7'h0, irq_pin_oe_n}, 8'h01);
        pin(1'h0, 12);
        @(posedge clk);
        clk_en <= 1'h0;
        // a clear while frozen must be ignored
        host.clr;
        quiet(1'h0);
        check({7'h0, ara_ack}, 8'h00);
        @(posedge clk);
        clk_en <= 1'h1;
        host.clr;
        pin(1'h1, 2);
        host.wr(A, 8'h17);
        host.conv(1'h1);
        pin(1'h0, 3);
        @(posedge clk);
        reset <= 1'h1;
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        t_reset;
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        t_reset;
        t_force;
        t_modes;
        t_persist;
        t_halt;
        t_long;
        stop_test;
    end
    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        #100000;
        error_cnt++;
        stop_test;
    end
endmodule // testbench
`default_nettype wire
